// ===== sim/timer16_compare_capture_irq_tb.sv
// Self-checking bench of the compare, capture and interrupt flag block
module timer16_compare_capture_irq_tb
  import cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] IDLE = 16'hfff0;

  logic        mclk, rst_n, gie, capture_pin, comparator_out, ack_en;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cap_top, match_a, match_b, lvl;
  logic [7:0]  awaddr, araddr, lo;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb, mode, delay;
  logic [15:0] cmpa_val, cmpb_val, capt_val, cmp_a, cmp_b, v;
  logic [33:0] re;
  counter_in_t cin;
  irq_t        irq_req, vack;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;

  timer16_compare_capture_irq i_timer16_compare_capture_irq (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .counter_in(cin),
    .waveform_mode_select(mode), .compare_a_value(cmpa_val),
    .compare_b_value(cmpb_val), .capture_value(capt_val),
    .capture_is_top(cap_top), .match_a(match_a), .match_b(match_b),
    .capture_pin(capture_pin), .comparator_out(comparator_out),
    .global_irq_enable(gie), .vector_ack(vack), .irq_req(irq_req));

  vector_ctrl_model i_vector_ctrl_model (
    .mclk(mclk), .rst_n(rst_n), .irq_req(irq_req), .ack_en(ack_en),
    .delay(delay), .vector_ack(vack));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Bus write; handshakes judged mid-cycle, released after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic aw_t, w_t, b_t;
    bq.push_back(er);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h0, d};
    bready  <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge mclk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      @(posedge mclk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end
    // bready stays up: back-to-back calls never toggle it in one step
  endtask

  // Bus read; the expected answer is noted before the request
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic ar_t, r_t;
    rq.push_back({er, 24'h0, d});
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    r_t = 1'b0;
    while (!r_t)
    begin
      @(negedge mclk);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      @(posedge mclk);
      if (ar_t)
        arvalid <= 1'b0;
    end
    // rready stays up for the same reason
  endtask

  // One counter event, then the idle count so nothing else matches
  task automatic ev(input int i);
    case (i)
      0: cin.at_top <= 1'b1;
      1: cin.count <= cmp_a;
      2: cin.count <= cmp_b;
      default: cin.overflow <= 1'b1;
    endcase
    @(posedge mclk);
    cin.at_top   <= 1'b0;
    cin.overflow <= 1'b0;
    cin.count    <= IDLE;
    cyc(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Answer watcher; data of an error answer is not compared
  always @(posedge mclk)
  begin
    if (bvalid && bready)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid && rready)
    begin
      re = rq.pop_front();
      chk("rdata", re,
          {rresp, (re[33:32] === RESP_SLVERR) ? re[31:0] : rdata});
    end
  end

  // Hang guard, well above the length of the run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {mclk, rst_n, gie, capture_pin, comparator_out, ack_en} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, delay} = '0;
    wstrb = 4'hf;
    cin = '0;
    cin.count = IDLE;
    void'($urandom(7409));
    cyc(6);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ADDR_MASK, MASK_RST);
    rd(ADDR_FLAGS, FLAGS_RST);
    wr(ADDR_MASK, 8'hff);
    rd(ADDR_MASK, OWN_BITS);
    wr(8'h40, 8'h00, RESP_SLVERR);
    rd(8'h40, 8'h00, RESP_SLVERR);
    $display("test registers finished");
    for (int c = 0; c < 2; c++)
    begin
      v  = 16'($urandom_range(16'h7fff, 1));
      lo = c ? ADDR_CMPB_LO : ADDR_CMPA_LO;
      wr(lo + 8'h04, v[15:8]);
      chk("cmp_hi", 34'h0, {18'h0, c ? cmpb_val : cmpa_val});
      wr(lo, v[7:0]);
      chk("cmp", {18'h0, v}, {18'h0, c ? cmpb_val : cmpa_val});
      rd(lo, v[7:0]);
      rd(lo + 8'h04, v[15:8]);
      if (c)
        cmp_b = v;
      else
        cmp_a = v;
      cin.force_a <= (c == 0);
      cin.force_b <= (c == 1);
      @(negedge mclk);
      chk("force", c ? 34'h1 : 34'h2, {32'h0, match_a, match_b});
      @(posedge mclk);
      cin.force_a <= 1'b0;
      cin.force_b <= 1'b0;
      rd(ADDR_FLAGS, 8'h00);
      ev(c + 1);
      rd(ADDR_FLAGS, c ? 8'h08 : 8'h10);
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, c ? 8'h08 : 8'h10);
      wr(ADDR_FLAGS, 8'hff);
      rd(ADDR_FLAGS, 8'h00);
    end
    $display("test compare finished");
    for (int k = 0; k < 3; k++)
    begin
      v   = 16'($urandom_range(16'hffff, 16'h8000));
      lvl = (k != 0);
      wr(ADDR_CTRL, {6'h0, k == 2, lvl});
      cin.count <= v ^ 16'h00ff;
      if (k == 2)
        comparator_out <= ~lvl;
      else
        capture_pin <= ~lvl;
      cyc(6);
      rd(ADDR_FLAGS, 8'h00);
      cin.count <= v;
      if (k == 2)
        comparator_out <= lvl;
      else
        capture_pin <= lvl;
      cyc(6);
      cin.count <= IDLE;
      rd(ADDR_FLAGS, 8'h20);
      rd(ADDR_CAPT_LO, v[7:0]);
      rd(ADDR_CAPT_HI, v[15:8]);
      wr(ADDR_FLAGS, 8'h20);
    end
    wr(ADDR_CTRL, 8'hc1);
    chk("top", {12'h0, MODE_CLR_CAPT, 1'b1, v},
        {12'h0, mode, cap_top, capt_val});
    capture_pin <= 1'b0;
    cyc(6);
    cin.count <= v ^ 16'h0f0f;
    capture_pin <= 1'b1;
    cyc(6);
    cin.count <= IDLE;
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_CAPT_LO, v[7:0]);
    $display("test capture finished");
    for (int i = 0; i < 4; i++)
    begin
      gie <= 1'b1;
      wr(ADDR_MASK, ~(8'h20 >> i) & OWN_BITS);
      ev(i);
      chk("irq_masked", 34'h0, {30'h0, irq_req});
      wr(ADDR_MASK, 8'h20 >> i);
      chk("irq", {30'h0, 4'h8 >> i}, {30'h0, irq_req});
      gie <= 1'b0;
      @(negedge mclk);
      chk("irq_gie", 34'h0, {30'h0, irq_req});
      @(posedge mclk);
      gie <= 1'b1;
      ack_en <= i[0];
      delay <= 4'($urandom_range(5, 0));
      cyc(10);
      ack_en <= 1'b0;
      if (!i[0])
        wr(ADDR_FLAGS, 8'h20 >> i);
      rd(ADDR_FLAGS, 8'h00);
    end
    $display("test interrupts finished");
    print_verdict();
  end
endmodule

// ===== sim/vector_ctrl_model.sv
// Model of the interrupt vector controller facing the flag logic
module vector_ctrl_model
  import cc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Requests and pacing
  input  wire irq_t       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] delay,
  // Vector execution strobe
  output irq_t            vector_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] req;
  logic [3:0] wait_cnt;

  assign req = irq_req;

  // Runs the highest pending vector after a delay, one pulse at a time
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vector_ack <= '0;
      wait_cnt   <= '0;
    end
    else
    begin
      vector_ack <= '0;
      wait_cnt   <= '0;
      // A pulse must clear the flag before the next one is sent
      if (ack_en && (req != 4'h0) && (vector_ack == '0))
      begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == delay)
          vector_ack <= req[3] ? 4'h8 : req[2] ? 4'h4 : req[1] ? 4'h2 : 4'h1;
      end
    end
  end
endmodule

// ===== verilog/cc_pkg.sv
// Package: register map, field positions and types of the compare/capture block
// Functional notes
// - Both compare values are matched against the counter every cycle.
// - Compare writes commit both bytes at once via the shared high-byte latch.
// - Capture event copies the counter value into the capture register.
// - Capture register is offered as TOP when the mode selects it.
// - Capture reads return a coherent 16-bit value via the shared latch.
// - Capture flag with mask bit 5 and global enable requests an interrupt.
// - Compare A flag with mask bit 4 and global enable requests an interrupt.
// - Compare B flag with mask bit 3 and global enable requests an interrupt.
// - Overflow flag with mask bit 2 and global enable requests an interrupt.
// - Capture pin event sets the capture flag, bit 5.
// - With capture as TOP, reaching TOP sets the capture flag instead.
// - Capture flag clears on vector execution or a written one.
// - Compare A flag sets two cycles after counter equals compare A.
// - Force-compare A never sets the compare A flag.
// - Compare A flag clears on vector execution or a written one.
// - Compare B flag sets two cycles after counter equals compare B.
// - Force-compare B never sets the compare B flag.
// - Compare B flag clears on vector execution or a written one.
// - Overflow flag sets at the mode's overflow point.
// - Overflow flag clears on vector execution or a written one.
// - Capture edge select: zero falling edge, one rising edge.
// - With capture as TOP the pin is disconnected, no pin capture.
package cc_pkg;

  // Byte addresses of the 8-bit register views, one per word
  localparam logic [7:0] ADDR_CMPA_LO  = 8'h00;
  localparam logic [7:0] ADDR_CMPA_HI  = 8'h04;
  localparam logic [7:0] ADDR_CMPB_LO  = 8'h08;
  localparam logic [7:0] ADDR_CMPB_HI  = 8'h0c;
  localparam logic [7:0] ADDR_CAPT_LO  = 8'h10;
  localparam logic [7:0] ADDR_CAPT_HI  = 8'h14;
  localparam logic [7:0] ADDR_MASK     = 8'h18;
  localparam logic [7:0] ADDR_FLAGS    = 8'h1c;
  localparam logic [7:0] ADDR_CTRL     = 8'h20;

  // Mask and flag bit positions shared by both registers
  localparam int BIT_CAPT = 5;
  localparam int BIT_CMPA = 4;
  localparam int BIT_CMPB = 3;
  localparam int BIT_OVF  = 2;
  localparam logic [7:0] OWN_BITS = 8'h3c;

  // Control register fields
  localparam int CTRL_EDGE    = 0;
  localparam int CTRL_ACMP    = 1;
  localparam int CTRL_MODE_LO = 4;

  // Reset values
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] VAL_RST   = 16'h0000;

  // Waveform modes that use the capture register as TOP
  localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
  localparam logic [3:0] MODE_PC_CAPT   = 4'ha;
  localparam logic [3:0] MODE_CLR_CAPT  = 4'hc;
  localparam logic [3:0] MODE_FAST_CAPT = 4'he;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Events from the counter core
  typedef struct packed {
    logic [15:0] count;
    logic        overflow;
    logic        at_top;
    logic        force_a;
    logic        force_b;
  } counter_in_t;

  // Interrupt requests and vector acknowledges
  typedef struct packed {
    logic capt;
    logic cmpa;
    logic cmpb;
    logic ovf;
  } irq_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cmpa_r;
    logic [15:0] cmpb_r;
    logic [15:0] capt_r;
    logic [7:0]  temp_r;
    logic [7:0]  mask_r;
    logic [7:0]  flags_r;
    logic [7:0]  ctrl_r;
    logic        pin_s1_r;
    logic        pin_s2_r;
    logic        pin_d_r;
    logic        acmp_s1_r;
    logic        acmp_s2_r;
    logic        acmp_d_r;
    logic        match_a_r;
    logic        match_b_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [7:0]  wdata_r;
    logic        wstrb0_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
  } state_t;

endpackage

// ===== verilog/timer16_compare_capture_irq.sv
// Compare, capture and interrupt-flag logic of a 16-bit timer with AXI4-Lite
module timer16_compare_capture_irq
  import cc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Counter core
  input  wire counter_in_t counter_in,
  output logic [3:0]       waveform_mode_select,
  output logic [15:0]      compare_a_value,
  output logic [15:0]      compare_b_value,
  output logic [15:0]      capture_value,
  output logic             capture_is_top,
  output logic             match_a,
  output logic             match_b,
  // Pins from outside the clock domain
  input  wire logic        capture_pin,
  input  wire logic        comparator_out,
  // Interrupt controller
  input  wire logic        global_irq_enable,
  input  wire irq_t        vector_ack,
  output irq_t             irq_req
);

  state_t s_r;
  state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Modes that take TOP from the capture register
  function automatic logic capt_top(input logic [3:0] m);
    capt_top = (m == MODE_PFC_CAPT) || (m == MODE_PC_CAPT) ||
               (m == MODE_CLR_CAPT) || (m == MODE_FAST_CAPT);
  endfunction

  // Edge detect by selected polarity
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic rising);
    edge_hit = rising ? (cur & ~prev) : (~cur & prev);
  endfunction

  logic [3:0]  mode;
  logic        top_capt;
  logic        capt_src;
  logic        capt_prev;
  logic        capt_evt;
  logic        eq_a;
  logic        eq_b;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  set_v;
  logic [7:0]  ack_v;
  logic [7:0]  w1c_v;
  logic [15:0] wr16;

  ////////////////////////////////////////////////////////////////////////
  // Event decode

  // Mode and trigger selection
  always_comb
  begin
    mode     = s_r.ctrl_r[CTRL_MODE_LO +: 4];
    top_capt = capt_top(mode);
    capt_src = s_r.ctrl_r[CTRL_ACMP] ? s_r.acmp_s2_r : s_r.pin_s2_r;
    capt_prev = s_r.ctrl_r[CTRL_ACMP] ? s_r.acmp_d_r : s_r.pin_d_r;
    // Pin disconnected while capture serves as TOP
    capt_evt = ~top_capt &&
               edge_hit(capt_src, capt_prev,
                        s_r.ctrl_r[CTRL_EDGE]);
    eq_a = (counter_in.count == s_r.cmpa_r);
    eq_b = (counter_in.count == s_r.cmpb_r);
  end

  // Flag sources; force strobes are deliberately not wired in
  always_comb
  begin
    set_v = 8'h00;
    set_v[BIT_CAPT] = top_capt ? counter_in.at_top
                               : capt_evt;
    set_v[BIT_CMPA] = s_r.match_a_r;
    set_v[BIT_CMPB] = s_r.match_b_r;
    set_v[BIT_OVF]  = counter_in.overflow;
    ack_v = 8'h00;
    ack_v[BIT_CAPT] = vector_ack.capt;
    ack_v[BIT_CMPA] = vector_ack.cmpa;
    ack_v[BIT_CMPB] = vector_ack.cmpb;
    ack_v[BIT_OVF]  = vector_ack.ovf;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // One write and one read in flight; ready only while slot empty
  assign s_axi_awready = ~s_r.aw_got_r & ~s_r.bvalid_r;
  assign s_axi_wready  = ~s_r.w_got_r & ~s_r.bvalid_r;
  assign s_axi_arready = ~s_r.rvalid_r;
  assign wr_fire = (s_r.aw_got_r | (s_axi_awvalid & s_axi_awready)) &&
                   (s_r.w_got_r | (s_axi_wvalid & s_axi_wready));
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [7:0] wa;
    logic [7:0] wd;
    logic       we;
    wa = s_r.aw_got_r ? s_r.awaddr_r : s_axi_awaddr;
    wd = s_r.w_got_r ? s_r.wdata_r : s_axi_wdata[7:0];
    we = s_r.w_got_r ? s_r.wstrb0_r : s_axi_wstrb[0];
    s_nxt = s_r;
    w1c_v = 8'h00;
    wr16 = {s_r.temp_r, wd};

    // Two-flop synchronisers, then edge history
    s_nxt.pin_s1_r  = capture_pin;
    s_nxt.pin_s2_r  = s_r.pin_s1_r;
    s_nxt.pin_d_r   = s_r.pin_s2_r;
    s_nxt.acmp_s1_r = comparator_out;
    s_nxt.acmp_s2_r = s_r.acmp_s1_r;
    s_nxt.acmp_d_r  = s_r.acmp_s2_r;

    // Flag follows the match by two cycles
    s_nxt.match_a_r = eq_a;
    s_nxt.match_b_r = eq_b;

    // Capture copies the running counter
    if (capt_evt)
      s_nxt.capt_r = counter_in.count;

    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_got_r = 1'b1;
      s_nxt.awaddr_r = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_got_r  = 1'b1;
      s_nxt.wdata_r  = s_axi_wdata[7:0];
      s_nxt.wstrb0_r = s_axi_wstrb[0];
    end

    // Register writes; high byte goes to latch, low byte commits
    if (wr_fire)
    begin
      s_nxt.aw_got_r = 1'b0;
      s_nxt.w_got_r  = 1'b0;
      s_nxt.bvalid_r = 1'b1;
      s_nxt.bresp_r  = RESP_OKAY;
      if (we)
      begin
        unique case (wa)
          ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAPT_HI: s_nxt.temp_r = wd;
          ADDR_CMPA_LO: s_nxt.cmpa_r = wr16;
          ADDR_CMPB_LO: s_nxt.cmpb_r = wr16;
          ADDR_CAPT_LO: s_nxt.capt_r = wr16;
          ADDR_MASK:    s_nxt.mask_r = wd & OWN_BITS;
          ADDR_FLAGS:   w1c_v = wd & OWN_BITS;
          ADDR_CTRL:    s_nxt.ctrl_r = wd;
          default:      s_nxt.bresp_r = RESP_SLVERR;
        endcase
      end
    end
    if (s_r.bvalid_r && s_axi_bready)
      s_nxt.bvalid_r = 1'b0;

    // Set wins over any clear in the same cycle
    s_nxt.flags_r = (s_r.flags_r & ~(w1c_v | ack_v)) | set_v;

    // Reads; low byte of a 16-bit register latches its high byte
    if (rd_fire)
    begin
      s_nxt.rvalid_r = 1'b1;
      s_nxt.rresp_r  = RESP_OKAY;
      s_nxt.rdata_r  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CMPA_LO:
        begin
          s_nxt.rdata_r[7:0] = s_r.cmpa_r[7:0];
          s_nxt.temp_r = s_r.cmpa_r[15:8];
        end
        ADDR_CMPB_LO:
        begin
          s_nxt.rdata_r[7:0] = s_r.cmpb_r[7:0];
          s_nxt.temp_r = s_r.cmpb_r[15:8];
        end
        ADDR_CAPT_LO:
        begin
          s_nxt.rdata_r[7:0] = s_r.capt_r[7:0];
          s_nxt.temp_r = s_r.capt_r[15:8];
        end
        ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAPT_HI:
          s_nxt.rdata_r[7:0] = s_r.temp_r;
        ADDR_MASK:  s_nxt.rdata_r[7:0] = s_r.mask_r;
        ADDR_FLAGS: s_nxt.rdata_r[7:0] = s_r.flags_r;
        ADDR_CTRL:  s_nxt.rdata_r[7:0] = s_r.ctrl_r;
        default:    s_nxt.rresp_r = RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid_r && s_axi_rready)
      s_nxt.rvalid_r = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.mask_r  <= MASK_RST;
      s_r.flags_r <= FLAGS_RST;
      s_r.cmpa_r  <= VAL_RST;
      s_r.cmpb_r  <= VAL_RST;
      s_r.capt_r  <= VAL_RST;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_bvalid = s_r.bvalid_r;
  assign s_axi_bresp  = s_r.bresp_r;
  assign s_axi_rvalid = s_r.rvalid_r;
  assign s_axi_rdata  = s_r.rdata_r;
  assign s_axi_rresp  = s_r.rresp_r;
  assign waveform_mode_select = mode;
  assign compare_a_value = s_r.cmpa_r;
  assign compare_b_value = s_r.cmpb_r;
  assign capture_value   = s_r.capt_r;
  assign capture_is_top  = top_capt;
  // Match is live for the waveform unit; force strobes merge there
  assign match_a = eq_a | counter_in.force_a;
  assign match_b = eq_b | counter_in.force_b;

  // Requests gated by mask and global enable
  always_comb
  begin
    irq_req.capt = global_irq_enable & s_r.mask_r[BIT_CAPT] &
                   s_r.flags_r[BIT_CAPT];
    irq_req.cmpa = global_irq_enable & s_r.mask_r[BIT_CMPA] &
                   s_r.flags_r[BIT_CMPA];
    irq_req.cmpb = global_irq_enable & s_r.mask_r[BIT_CMPB] &
                   s_r.flags_r[BIT_CMPB];
    irq_req.ovf  = global_irq_enable & s_r.mask_r[BIT_OVF] &
                   s_r.flags_r[BIT_OVF];
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Compare flags trail the match by two cycles; force strobes never count
  AST_CMPA_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (counter_in.count == s_r.cmpa_r) |=> ##1 s_r.flags_r[BIT_CMPA])
    else $error("compare A flag not set after match");

  AST_CMPB_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (counter_in.count == s_r.cmpb_r) |=> ##1 s_r.flags_r[BIT_CMPB])
    else $error("compare B flag not set after match");

  AST_FORCE_A: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!s_r.flags_r[BIT_CMPA] && !s_r.match_a_r) |=> !s_r.flags_r[BIT_CMPA])
    else $error("compare A flag set without match");

  AST_FORCE_B: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!s_r.flags_r[BIT_CMPB] && !s_r.match_b_r) |=> !s_r.flags_r[BIT_CMPB])
    else $error("compare B flag set without match");

  // Capture source and TOP handling
  AST_CAPT_COPY: assert property (@(posedge mclk)
    disable iff (!rst_n)
    capt_evt |=> (s_r.capt_r == $past(counter_in.count)) &&
                 s_r.flags_r[BIT_CAPT])
    else $error("capture did not copy counter");

  AST_TOP_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (top_capt && counter_in.at_top) |=> s_r.flags_r[BIT_CAPT])
    else $error("capture flag not set at TOP");

  AST_NO_PIN_TOP: assert property (@(posedge mclk)
    disable iff (!rst_n)
    top_capt |-> !capt_evt)
    else $error("pin capture while capture is TOP");

  // Requests are gated by mask and global enable
  AST_IRQ_A: assert property (@(posedge mclk)
    disable iff (!rst_n)
    irq_req.cmpa == (global_irq_enable && s_r.mask_r[BIT_CMPA] &&
                     s_r.flags_r[BIT_CMPA]))
    else $error("compare A request mismatch");

  AST_IRQ_GATE: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !global_irq_enable |-> (irq_req == 4'h0))
    else $error("request while interrupts globally off");

  // Overflow flag follows the core's pulse
  AST_OVF_SET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    counter_in.overflow |=> s_r.flags_r[BIT_OVF])
    else $error("overflow flag not set");

  AST_OVF_ACK: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (vector_ack.ovf && !counter_in.overflow) |=> !s_r.flags_r[BIT_OVF])
    else $error("overflow flag not cleared by vector");

  // Clears by vector or written one; a same-cycle set is exempt
  AST_CAPT_CLR: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ((w1c_v[BIT_CAPT] || vector_ack.capt) && !set_v[BIT_CAPT])
      |=> !s_r.flags_r[BIT_CAPT])
    else $error("capture flag not cleared");

  AST_CMPA_CLR: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ((w1c_v[BIT_CMPA] || vector_ack.cmpa) && !set_v[BIT_CMPA])
      |=> !s_r.flags_r[BIT_CMPA])
    else $error("compare A flag not cleared");

  AST_CMPB_CLR: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ((w1c_v[BIT_CMPB] || vector_ack.cmpb) && !set_v[BIT_CMPB])
      |=> !s_r.flags_r[BIT_CMPB])
    else $error("compare B flag not cleared");

  // Zero writes keep a flag; decoded clear, not the raw bus word
  AST_W1C_ZERO: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (s_r.flags_r[BIT_CAPT] && !vector_ack.capt && !w1c_v[BIT_CAPT])
      |=> s_r.flags_r[BIT_CAPT])
    else $error("capture flag lost without clear");

  AST_OWN_BITS: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ((s_r.mask_r | s_r.flags_r) & ~OWN_BITS) == 8'h00)
    else $error("bit of another timer held here");

  // Low-byte reads load the shared high-byte latch
  AST_CAPT_LATCH: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (rd_fire && (s_axi_araddr == ADDR_CAPT_LO))
      |=> (s_r.temp_r == $past(s_r.capt_r[15:8])))
    else $error("capture high byte not latched");

  AST_CMPA_LATCH: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (rd_fire && (s_axi_araddr == ADDR_CMPA_LO))
      |=> (s_r.temp_r == $past(s_r.cmpa_r[15:8])))
    else $error("compare A high byte not latched");

endmodule
